// file: bench/tb_top.sv
// self-checking bench of the real-time-clock counter block
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk = 1'b0, reset = 1'b1, clkEn = 1'b1, debugMode = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [2:0]  awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] d, v1, v2;
    int          errors = 0, checks_done = 0, cycles = 0, seed = 98;
    rtc_up_counter_alarm uut (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
        .debugMode(debugMode), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .irq(irq));
    always #10 sys_clk = ~sys_clk;
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // master holds each channel until its own handshake edge
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid === 1'b1 && bready));
        resp = bresp;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid === 1'b1 && rready));
        v = rdata;
        resp = rresp;
    endtask
    // polling stands in for fixed delays: status may lag the command
    task automatic poll(input string what, input int bitn, input logic val);
        int n;
        n = 0;
        do begin
            axr(rtc_pkg::OFF_EN, d);
            n++;
        end while (d[bitn] !== val && n < 40);
        chk(what, {31'h0, d[bitn]}, {31'h0, val});
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        poll("sysok", rtc_pkg::EN_SYSOK_BIT, 1'b1);
        poll("done", rtc_pkg::EN_DONE_BIT, 1'b1);
        chk("run idle", {31'h0, d[16]}, 32'h0);
        axr(rtc_pkg::OFF_MASK, d); chk("mask rst", d, rtc_pkg::MASK_RESET);
        axr(rtc_pkg::OFF_UPPER, d); chk("upper rst", d, rtc_pkg::CMP_RESET);
        axr(rtc_pkg::OFF_ALARM, d); chk("alarm rst", d, rtc_pkg::CMP_RESET);
        axr(rtc_pkg::OFF_RAW, d); chk("raw rst", d, 32'h0);
        axr(rtc_pkg::OFF_MASKED, d); chk("masked rst", d, 32'h0);
        axr(rtc_pkg::OFF_VALUE, d); chk("value rst", d, 32'h0);
        axr(8'h90, d); chk("unmapped rd", {resp, d[29:0]}, {rtc_pkg::RESP_DECERR, 30'h0});
        axw(8'h94, 32'h1); chk("unmapped wr", {30'h0, resp}, {30'h0, rtc_pkg::RESP_DECERR});
        // random register traffic with read-back through field masks
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            axw(rtc_pkg::OFF_MASK, d); axr(rtc_pkg::OFF_MASK, v1);
            chk("mask rw", v1, d & rtc_pkg::SRC_BITS);
            axw(rtc_pkg::OFF_CTRL, d); axr(rtc_pkg::OFF_CTRL, v1);
            chk("ctrl rw", v1, d & rtc_pkg::CTRL_BITS);
            axw(rtc_pkg::OFF_DIV, d); axr(rtc_pkg::OFF_DIV, v1);
            chk("div rw", v1, d & rtc_pkg::DIV_BITS);
            axw(rtc_pkg::OFF_ALARM, d); axr(rtc_pkg::OFF_ALARM, v1);
            chk("alarm rw", v1, d);
        end
        // small upper and alarm, upper unmasked, alarm masked
        axw(rtc_pkg::OFF_CTRL, 32'h0); axw(rtc_pkg::OFF_DIV, 32'h0);
        axw(rtc_pkg::OFF_UPPER, 32'h5); axw(rtc_pkg::OFF_ALARM, 32'h3);
        axw(rtc_pkg::OFF_MASK, 32'h0000_8000);
        axw(rtc_pkg::OFF_EN, 32'h4);
        poll("done rst", rtc_pkg::EN_DONE_BIT, 1'b1);
        axr(rtc_pkg::OFF_VALUE, d); chk("value zero", d, 32'h0);
        chk("rd okay", {30'h0, resp}, {30'h0, rtc_pkg::RESP_OKAY});
        axw(rtc_pkg::OFF_EN, 32'h1);
        poll("run on", rtc_pkg::EN_RUN_BIT, 1'b1);
        repeat (20) @(posedge sys_clk);
        axw(rtc_pkg::OFF_EN, 32'h2);
        poll("run off", rtc_pkg::EN_RUN_BIT, 1'b0);
        axr(rtc_pkg::OFF_VALUE, v1); axr(rtc_pkg::OFF_VALUE, v2);
        chk("stopped", v2, v1);
        chk("wrap", {31'h0, v1 <= 32'h5}, 32'h1);
        axr(rtc_pkg::OFF_RAW, d); chk("raw set", d, rtc_pkg::SRC_BITS);
        axr(rtc_pkg::OFF_MASKED, d); chk("masked", d, 32'h0001_0000);
        chk("irq on", {31'h0, irq}, 32'h1);
        axw(rtc_pkg::OFF_RAW, 32'h0); axr(rtc_pkg::OFF_RAW, d);
        chk("w0 keeps", d, rtc_pkg::SRC_BITS);
        axw(rtc_pkg::OFF_RAW, 32'h0001_0000); axr(rtc_pkg::OFF_RAW, d);
        chk("w1c", d, 32'h0000_8000);
        axr(rtc_pkg::OFF_MASKED, d);
        chk("masked off", d, 32'h0);
        chk("irq off", {31'h0, irq}, 32'h0);
        axw(rtc_pkg::OFF_RAW, 32'h0000_8000); axr(rtc_pkg::OFF_RAW, d);
        chk("alarm clr", d, 32'h0);
        // debug halt with action bit clear, then counting with it set
        axw(rtc_pkg::OFF_UPPER, 32'hffff_ffff); axw(rtc_pkg::OFF_ALARM, 32'hffff_ffff);
        axw(rtc_pkg::OFF_EN, 32'h4);
        poll("done2", rtc_pkg::EN_DONE_BIT, 1'b1);
        debugMode <= 1'b1;
        axw(rtc_pkg::OFF_EN, 32'h1);
        poll("dbg halt", rtc_pkg::EN_RUN_BIT, 1'b0);
        axr(rtc_pkg::OFF_VALUE, v1); axr(rtc_pkg::OFF_VALUE, v2);
        chk("dbg frozen", v2, v1);
        axw(rtc_pkg::OFF_CTRL, 32'h10);
        poll("dbg run", rtc_pkg::EN_RUN_BIT, 1'b1);
        debugMode <= 1'b0;
        // divider of 2: one tick every four clocks
        axw(rtc_pkg::OFF_EN, 32'h2);
        axw(rtc_pkg::OFF_DIV, 32'h0000_0200);
        axw(rtc_pkg::OFF_EN, 32'h4);
        poll("done3", rtc_pkg::EN_DONE_BIT, 1'b1);
        axw(rtc_pkg::OFF_EN, 32'h1);
        axr(rtc_pkg::OFF_VALUE, v1);
        repeat (40) @(posedge sys_clk);
        axr(rtc_pkg::OFF_VALUE, v2);
        chk("rate", {31'h0, (v2 - v1 >= 32'd10) && (v2 - v1 <= 32'd11)}, 32'h1);
        // clock enable low must freeze the running counter
        axr(rtc_pkg::OFF_VALUE, v1);
        clkEn <= 1'b0;
        repeat (30) @(posedge sys_clk);
        clkEn <= 1'b1;
        axr(rtc_pkg::OFF_VALUE, v2);
        chk("frozen", {31'h0, v2 - v1 <= 32'd1}, 32'h1);
        axw(rtc_pkg::OFF_EN, 32'h2);
        tally_and_finish();
    end
endmodule

// file: verilog/rtc_pkg.sv
// constants of the real-time-clock up-counter with alarm
// ****************************************************************
// How it works
// - bit 18 shows system reset released
// - counter reset clears done bit 17 until finished
// - bit 16 shows counter really running
// - write 1 to bit 2 zeroes the counter
// - write 1 to bit 1 stops counting
// - write 1 to bit 0 starts counting
// - upper reach sets sticky bit 16, write-one-clear
// - alarm reach sets sticky bit 15, write-one-clear
// - all-ones compare value acts as overflow flag
// - masked status is raw and not mask
// - interrupt output is or of masked bits
// - mask bits 16 and 15 reset to one
// - counter wraps to zero after upper value
// - upper value shadowed, applied at wrap or reset
// - tick rate is clock over two to divider
// - debug halts counting unless debug-action bit set
// ****************************************************************
package rtc_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFF_EN         = 8'h00;
    localparam logic [7:0]  OFF_RAW        = 8'h20;
    localparam logic [7:0]  OFF_MASKED     = 8'h24;
    localparam logic [7:0]  OFF_MASK       = 8'h28;
    localparam logic [7:0]  OFF_CTRL       = 8'h40;
    localparam logic [7:0]  OFF_VALUE      = 8'h50;
    localparam logic [7:0]  OFF_UPPER      = 8'h60;
    localparam logic [7:0]  OFF_ALARM      = 8'h70;
    localparam logic [7:0]  OFF_DIV        = 8'h80;
    // ************************************************************
    // fields
    // ************************************************************
    localparam int          EN_START_BIT   = 0;
    localparam int          EN_STOP_BIT    = 1;
    localparam int          EN_RESET_BIT   = 2;
    localparam int          EN_RUN_BIT     = 16;
    localparam int          EN_DONE_BIT    = 17;
    localparam int          EN_SYSOK_BIT   = 18;
    localparam int          UPP_BIT        = 16;
    localparam int          ALARM_BIT      = 15;
    localparam int          CTRL_DBG_BIT   = 4;
    localparam int          DIV_LSB        = 8;
    localparam logic [31:0] SRC_BITS       = 32'h0001_8000;
    localparam logic [31:0] CTRL_BITS      = 32'h0000_0310;
    localparam logic [31:0] DIV_BITS       = 32'h0000_0f00;
    // ************************************************************
    // reset values and timing
    // ************************************************************
    localparam logic [31:0] MASK_RESET     = 32'h0001_8000;
    localparam logic [31:0] CMP_RESET      = 32'hffff_ffff;
    localparam logic [31:0] ZERO_RESET     = 32'h0000_0000;
    localparam logic [1:0]  RST_CYCLES     = 2'h2;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_DECERR    = 2'h3;
endpackage

// file: verilog/rtc_up_counter_alarm.sv
// real-time-clock up-counter with upper wrap, alarm and axi4-lite registers
`timescale 1ns/1ps
module rtc_up_counter_alarm (
    // clock, reset, freeze
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // debug state of the core
    input  wire logic        debugMode,
    // axi4-lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    // axi4-lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // interrupt
    output logic             irq
);
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] applyStrb(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb,
                                              input logic [31:0] keep);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return v & keep;
    endfunction

    function automatic logic isWord(input logic [7:0] a, input logic [7:0] off);
        return {a[7:2], 2'b00} == off;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic        irq_reg;
    logic        awHave_reg;
    logic        wHave_reg;
    logic [7:0]  wrAddr_reg;
    logic [31:0] wrData_reg;
    logic [3:0]  wrStrb_reg;
    logic        sysOk_reg;
    logic        rstDone_reg;
    logic [1:0]  rstCnt_reg;
    logic        run_reg;
    logic [31:0] count_reg;
    logic [31:0] upperSw_reg;
    logic [31:0] upperAct_reg;
    logic [31:0] alarm_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] div_reg;
    logic [31:0] mask_reg;
    logic [31:0] raw_reg;
    logic [14:0] divCnt_reg;

    logic        wrHit;
    logic        enWrite;
    logic        rstCmd;
    logic        startCmd;
    logic        stopCmd;
    logic        counting;
    logic        tick;
    logic        hitUpper;
    logic        hitAlarm;
    logic [31:0] masked;
    logic [31:0] rdMux;
    logic        rdMapped;
    logic [3:0]  divSel;
    logic [15:0] divMask;

    assign awready = awready_reg;
    assign wready  = wready_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign arready = arready_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;
    assign irq     = irq_reg;

    // ************************************************************
    // command decode
    // ************************************************************
    // one write at a time: the response holds off the next address
    assign wrHit    = awHave_reg && wHave_reg && !bvalid_reg;
    assign enWrite  = wrHit && isWord(wrAddr_reg, rtc_pkg::OFF_EN) && wrStrb_reg[0];
    // writing zero to a command bit does nothing
    assign rstCmd   = enWrite && wrData_reg[rtc_pkg::EN_RESET_BIT];
    assign startCmd = enWrite && wrData_reg[rtc_pkg::EN_START_BIT];
    assign stopCmd  = enWrite && wrData_reg[rtc_pkg::EN_STOP_BIT];

    // ************************************************************
    // counting
    // ************************************************************
    // single clock here, so commands reach the counter directly
    assign divSel   = div_reg[rtc_pkg::DIV_LSB +: 4];
    assign divMask  = 16'((17'h1 << divSel) - 17'h1);
    assign counting = run_reg && rstDone_reg
                      && (!debugMode || ctrl_reg[rtc_pkg::CTRL_DBG_BIT]);
    assign tick     = counting
                      && ((divCnt_reg & divMask[14:0]) == divMask[14:0]);
    // all-ones compare makes the reach flag an overflow flag
    assign hitUpper = tick && (count_reg == upperAct_reg);
    assign hitAlarm = tick && (count_reg == alarm_reg);
    assign masked   = raw_reg & ~mask_reg & rtc_pkg::SRC_BITS;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            divCnt_reg <= '0;
        end else if (clkEn) begin
            if (rstCmd || !counting) begin
                divCnt_reg <= '0;
            end else begin
                divCnt_reg <= divCnt_reg + 15'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_reg    <= rtc_pkg::ZERO_RESET;
            upperAct_reg <= rtc_pkg::CMP_RESET;
        end else if (clkEn) begin
            if (rstCmd) begin
                count_reg    <= '0;
                upperAct_reg <= upperSw_reg;
            end else if (hitUpper) begin
                count_reg    <= '0;
                upperAct_reg <= upperSw_reg;
            end else if (tick) begin
                count_reg    <= count_reg + 32'h1;
            end
        end
    end

    // ************************************************************
    // run, reset-done and system-reset status
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            run_reg <= 1'b0;
        end else if (clkEn) begin
            if (stopCmd) begin
                run_reg <= 1'b0;
            end else if (startCmd) begin
                run_reg <= 1'b1;
            end
        end
    end

    // counter reset runs a fixed few cycles; it also runs after power-up
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rstCnt_reg  <= rtc_pkg::RST_CYCLES;
            rstDone_reg <= 1'b0;
        end else if (clkEn) begin
            if (rstCmd) begin
                rstCnt_reg  <= rtc_pkg::RST_CYCLES;
                rstDone_reg <= 1'b0;
            end else if (rstCnt_reg != 2'h0) begin
                rstCnt_reg  <= rstCnt_reg - 2'h1;
                rstDone_reg <= (rstCnt_reg == 2'h1);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sysOk_reg <= 1'b0;
        end else if (clkEn) begin
            sysOk_reg <= 1'b1;
        end
    end

    // ************************************************************
    // software registers
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            upperSw_reg <= rtc_pkg::CMP_RESET;
            alarm_reg   <= rtc_pkg::CMP_RESET;
            ctrl_reg    <= rtc_pkg::ZERO_RESET;
            div_reg     <= rtc_pkg::ZERO_RESET;
            mask_reg    <= rtc_pkg::MASK_RESET;
        end else if (clkEn && wrHit) begin
            if (isWord(wrAddr_reg, rtc_pkg::OFF_UPPER)) begin
                upperSw_reg <= applyStrb(upperSw_reg, wrData_reg, wrStrb_reg, '1);
            end
            if (isWord(wrAddr_reg, rtc_pkg::OFF_ALARM)) begin
                alarm_reg <= applyStrb(alarm_reg, wrData_reg, wrStrb_reg, '1);
            end
            if (isWord(wrAddr_reg, rtc_pkg::OFF_CTRL)) begin
                ctrl_reg <= applyStrb(ctrl_reg, wrData_reg, wrStrb_reg, rtc_pkg::CTRL_BITS);
            end
            if (isWord(wrAddr_reg, rtc_pkg::OFF_DIV)) begin
                div_reg <= applyStrb(div_reg, wrData_reg, wrStrb_reg, rtc_pkg::DIV_BITS);
            end
            if (isWord(wrAddr_reg, rtc_pkg::OFF_MASK)) begin
                mask_reg <= applyStrb(mask_reg, wrData_reg, wrStrb_reg, rtc_pkg::SRC_BITS);
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            raw_reg <= rtc_pkg::ZERO_RESET;
        end else if (clkEn) begin
            logic [31:0] clr;
            logic [31:0] set;
            clr = '0;
            set = '0;
            if (wrHit && isWord(wrAddr_reg, rtc_pkg::OFF_RAW)) begin
                clr = applyStrb('0, wrData_reg, wrStrb_reg, rtc_pkg::SRC_BITS);
            end
            set[rtc_pkg::UPP_BIT]   = hitUpper;
            set[rtc_pkg::ALARM_BIT] = hitAlarm;
            raw_reg <= (raw_reg & ~clr) | set;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_reg <= 1'b0;
        end else if (clkEn) begin
            irq_reg <= |masked;
        end
    end

    // ************************************************************
    // axi4-lite write channels
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            awready_reg <= 1'b1;
            awHave_reg  <= 1'b0;
            wrAddr_reg  <= '0;
        end else if (clkEn) begin
            if (awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                awHave_reg  <= 1'b1;
                wrAddr_reg  <= awaddr;
            end else if (bvalid_reg && bready) begin
                awready_reg <= 1'b1;
                awHave_reg  <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wready_reg <= 1'b1;
            wHave_reg  <= 1'b0;
            wrData_reg <= '0;
            wrStrb_reg <= '0;
        end else if (clkEn) begin
            if (wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                wHave_reg  <= 1'b1;
                wrData_reg <= wdata;
                wrStrb_reg <= wstrb;
            end else if (bvalid_reg && bready) begin
                wready_reg <= 1'b1;
                wHave_reg  <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= rtc_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (wrHit) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= (isWord(wrAddr_reg, rtc_pkg::OFF_EN)
                               || isWord(wrAddr_reg, rtc_pkg::OFF_RAW)
                               || isWord(wrAddr_reg, rtc_pkg::OFF_MASK)
                               || isWord(wrAddr_reg, rtc_pkg::OFF_CTRL)
                               || isWord(wrAddr_reg, rtc_pkg::OFF_UPPER)
                               || isWord(wrAddr_reg, rtc_pkg::OFF_ALARM)
                               || isWord(wrAddr_reg, rtc_pkg::OFF_DIV))
                              ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_DECERR;
            end else if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // axi4-lite read channels
    // ************************************************************
    always_comb begin
        rdMux    = '0;
        rdMapped = 1'b1;
        if (isWord(araddr, rtc_pkg::OFF_EN)) begin
            rdMux[rtc_pkg::EN_SYSOK_BIT] = sysOk_reg;
            rdMux[rtc_pkg::EN_DONE_BIT]  = rstDone_reg;
            rdMux[rtc_pkg::EN_RUN_BIT]   = counting;
        end else if (isWord(araddr, rtc_pkg::OFF_RAW)) begin
            rdMux = raw_reg;
        end else if (isWord(araddr, rtc_pkg::OFF_MASKED)) begin
            rdMux = masked;
        end else if (isWord(araddr, rtc_pkg::OFF_MASK)) begin
            rdMux = mask_reg;
        end else if (isWord(araddr, rtc_pkg::OFF_CTRL)) begin
            rdMux = ctrl_reg;
        end else if (isWord(araddr, rtc_pkg::OFF_VALUE)) begin
            rdMux = count_reg;
        end else if (isWord(araddr, rtc_pkg::OFF_UPPER)) begin
            rdMux = upperSw_reg;
        end else if (isWord(araddr, rtc_pkg::OFF_ALARM)) begin
            rdMux = alarm_reg;
        end else if (isWord(araddr, rtc_pkg::OFF_DIV)) begin
            rdMux = div_reg;
        end else begin
            rdMapped = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= rtc_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (arvalid && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rdata_reg   <= rdMux;
                rresp_reg   <= rdMapped ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_DECERR;
            end else if (rvalid_reg && rready) begin
                arready_reg <= 1'b1;
                rvalid_reg  <= 1'b0;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_sysOk;
        @(posedge sys_clk) disable iff (reset) clkEn && !reset |=> sysOk_reg;
    endproperty
    a_sysOk: assert property (p_sysOk) else $error("system status not set");

    property p_rstDoneLow;
        @(posedge sys_clk) disable iff (reset)
            clkEn && rstCmd |=> !rstDone_reg && count_reg == 32'h0;
    endproperty
    a_rstDoneLow: assert property (p_rstDoneLow) else $error("reset command ignored");

    property p_rstDoneBack;
        @(posedge sys_clk) disable iff (reset)
            clkEn && rstCmd ##1 clkEn ##1 clkEn |=> rstDone_reg;
    endproperty
    a_rstDoneBack: assert property (p_rstDoneBack) else $error("reset never done");

    property p_start;
        @(posedge sys_clk) disable iff (reset) clkEn && startCmd && !stopCmd |=> run_reg;
    endproperty
    a_start: assert property (p_start) else $error("start not applied");

    property p_stop;
        @(posedge sys_clk) disable iff (reset) clkEn && stopCmd |=> !run_reg && !counting;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not applied");

    property p_wrap;
        @(posedge sys_clk) disable iff (reset)
            clkEn && hitUpper && !rstCmd |=> count_reg == 32'h0 && raw_reg[16];
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap at upper value");

    property p_alarm;
        @(posedge sys_clk) disable iff (reset) clkEn && hitAlarm |=> raw_reg[15];
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm flag not set");

    property p_irq;
        @(posedge sys_clk) disable iff (reset)
            clkEn |=> irq_reg == |($past(raw_reg) & ~$past(mask_reg) & 32'h0001_8000);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt line wrong");

    property p_debugHalt;
        @(posedge sys_clk) disable iff (reset)
            clkEn && debugMode && !ctrl_reg[4] && !rstCmd |=> $stable(count_reg);
    endproperty
    a_debugHalt: assert property (p_debugHalt) else $error("counted in debug");

    property p_step;
        @(posedge sys_clk) disable iff (reset)
            clkEn && tick && !hitUpper && !rstCmd |=> count_reg == $past(count_reg) + 32'h1;
    endproperty
    a_step: assert property (p_step) else $error("bad increment");
endmodule
